// ---- hw/lsam_map.svh ----
// Register offsets, field positions, reset values and timing counts.
// Included by the link, sync and alarm monitor design files.
`ifndef LSAM_MAP_SVH
`define LSAM_MAP_SVH

`define LSAM_ADDR_TRIM_A 10'h037
`define LSAM_ADDR_SOFT_KICK 10'h06c
`define LSAM_ADDR_TRIM_B 10'h29a
`define LSAM_ADDR_TRIM_C 10'h29b
`define LSAM_ADDR_TRIM_D 10'h29c
`define LSAM_ADDR_LINK_CTL 10'h2c0
`define LSAM_ADDR_ALARM 10'h2c1
`define LSAM_ADDR_HIDE 10'h2c2
`define LSAM_ADDR_SUMMARY 10'h2c3
`define LSAM_ADDR_LANE_ERR 10'h2c4
`define LSAM_ADDR_LINK_STAT 10'h2c5
`define LSAM_ADDR_CHAN_PD 10'h2c6

`define LSAM_TRIM_A_RST 8'h4b
`define LSAM_TRIM_B_RST 8'h0f
`define LSAM_TRIM_C_RST 8'h04
`define LSAM_TRIM_D_RST 8'h1b
`define LSAM_CTL_RST 8'h00
`define LSAM_HIDE_RST 6'h00
`define LSAM_CHAN_PD_RST 2'h0

`define LSAM_CTL_LINK_EN 0
`define LSAM_CTL_SUBCLASS0 1
`define LSAM_CTL_ENC64 2
`define LSAM_CTL_TRIG_EN 3
`define LSAM_CTL_LP_BGCAL 4
`define LSAM_CTL_FG_CAL 5
`define LSAM_CTL_STAT_SEL 6
`define LSAM_CTL_GLOBAL_PD 7

`define LSAM_ALM_CPLL 0
`define LSAM_ALM_SPLL 1
`define LSAM_ALM_LINK 2
`define LSAM_ALM_SYSREF 3
`define LSAM_ALM_CLK 4
`define LSAM_ALM_FIFO 5

`define LSAM_MF_LEN 5'h1f
`define LSAM_ILAS_MF 2'h3
`define LSAM_TRANS_MIN_CLK 500
`define LSAM_TRANS_MAX_CLK 1000
`define LSAM_TRANS_LAST 10'h1f3

`endif

// ---- hw/lsam_pkg.sv ----
// Types shared by the link, sync and alarm monitor design files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lsam_pkg;
  typedef enum logic [1:0] {
    LSAM_LK_OFF = 2'b00,
    LSAM_LK_CGS = 2'b01,
    LSAM_LK_ILAS = 2'b10,
    LSAM_LK_DATA = 2'b11
  } lsam_link_t;

  typedef struct packed {
    logic [4:0] lmfc_cnt;
    lsam_link_t link_st;
    logic [1:0] ilas_cnt;
    logic [5:0] alarm;
    logic [7:0] lane_err;
    logic [5:0] hide;
    logic [7:0] ctl;
    logic [1:0] chan_pd;
    logic [31:0] trims;
    logic [9:0] trig_cnt;
    logic trig_busy;
    logic sysref_prev;
    logic ball_prev;
    logic pd_prev;
    logic [7:0] rdata;
    logic lmfc_edge;
    logic cgs_active;
    logic ilas_active;
    logic data_active;
    logic serdes_pd;
    logic fifo_rst;
    logic core_transition;
    logic calib_status_pin;
  } lsam_state_t;
endpackage
`default_nettype wire

// ---- hw/lsam_sync.sv ----
// Two flip-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit changes slowly against i_clk; no bus coherence kept.
`default_nettype none
module lsam_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ---- hw/lsam_top.sv ----
// Link timing, sticky alarm monitor and power mode registers.
// Assumes pins are asynchronous, channel clock ticks and lane FIFO
// errors come from logic on i_clk, and one host drives the plain port.
//
// Overview of operation
// - Outside subclass 0, sysref resets multiframe clock (8b/10b) or extended multiblock clock.
// - Without sysref in subclass 0, the multiframe clock runs freely.
// - In subclass 0 8b/10b, sync request starts code group sync then ILAS.
// - Six alarm conditions are detected.
// - Each alarm sets its own sticky bit, cleared by writing one.
// - Unhidden set alarm bits show in the summary register.
// - With alarm select, status pin is high while unhidden alarm present.
// - Channel clock mismatch for one cycle, with both channels powered, sets the clock upset flag.
// - Leaving global power-down sets clock upset; host clears it.
// - With link enabled, disturbed lane FIFO sets that lane's error flag.
// - Link enable low then high resets the serializer FIFO logic.
// - After reset the trims hold high performance values.
// - Third trim trades power against transition glitch size.
// - Triggered core transition lands 500 to 1000 clocks after trigger.
// - Foreground calibration makes no core transitions.
// - Link enable low holds link in reset, serializers down and gated.
//
// The implementer's own choice: the strobed register port.
`default_nettype none
`include "lsam_map.svh"
module lsam_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sysref,
  input wire logic i_sync_n,
  input wire logic i_cal_trigger_ball,
  input wire logic i_pd_pin,
  input wire logic i_cpll_lock,
  input wire logic i_spll_lock,
  input wire logic i_chan_a_clk_tick,
  input wire logic i_chan_b_clk_tick,
  input wire logic [7:0] i_lane_fifo_err,
  output logic [7:0] o_rdata,
  output logic o_lmfc_edge,
  output logic o_cgs_active,
  output logic o_ilas_active,
  output logic o_data_active,
  output logic o_serdes_pd,
  output logic o_fifo_rst,
  output logic [31:0] o_power_trims,
  output logic o_core_transition,
  output logic o_calib_status_pin
);
  lsam_pkg::lsam_state_t st_ff;
  lsam_pkg::lsam_state_t nxt_st;
  logic [5:0] pin_sync;
  logic sysref_s;
  logic sync_n_s;
  logic ball_s;
  logic pd_pin_s;
  logic cpll_s;
  logic spll_s;

  // Every pin passes two flip-flops before any logic reads it.
  lsam_sync #(
    .W(6)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_spll_lock, i_cpll_lock, i_pd_pin, i_cal_trigger_ball,
              i_sync_n, i_sysref}),
    .o_sync(pin_sync)
  );

  assign sysref_s = pin_sync[0];
  assign sync_n_s = pin_sync[1];
  assign ball_s = pin_sync[2];
  assign pd_pin_s = pin_sync[3];
  assign cpll_s = pin_sync[4];
  assign spll_s = pin_sync[5];

  logic link_en;
  logic sub0;
  logic enc64;
  logic fg_cal;
  logic wr_alarm;
  logic wr_lane;
  logic mf_wrap;
  logic sysref_rise;
  logic trig_event;
  logic trig_start;
  logic upset_event;
  logic global_pd;
  logic [5:0] alarm_cond;
  logic [5:0] summary;

  // Decoded controls and alarm causes for the current cycle.
  always_comb begin
    link_en = st_ff.ctl[`LSAM_CTL_LINK_EN];
    sub0 = st_ff.ctl[`LSAM_CTL_SUBCLASS0];
    enc64 = st_ff.ctl[`LSAM_CTL_ENC64];
    fg_cal = st_ff.ctl[`LSAM_CTL_FG_CAL];
    wr_alarm = i_wr && (i_addr == `LSAM_ADDR_ALARM);
    wr_lane = i_wr && (i_addr == `LSAM_ADDR_LANE_ERR);
    mf_wrap = (st_ff.lmfc_cnt == `LSAM_MF_LEN);
    sysref_rise = sysref_s && !st_ff.sysref_prev;
    global_pd = st_ff.ctl[`LSAM_CTL_GLOBAL_PD] || pd_pin_s;
    trig_event = (ball_s && !st_ff.ball_prev) ||
                 (i_wr && (i_addr == `LSAM_ADDR_SOFT_KICK));
    trig_start = trig_event && !st_ff.trig_busy && !fg_cal &&
                 st_ff.ctl[`LSAM_CTL_TRIG_EN] &&
                 st_ff.ctl[`LSAM_CTL_LP_BGCAL];
    // Channel compare only makes sense with both channels powered.
    upset_event = ((i_chan_a_clk_tick != i_chan_b_clk_tick) &&
                   st_ff.chan_pd == 2'h0) ||
                  (st_ff.pd_prev && !global_pd);
    alarm_cond = '0;
    alarm_cond[`LSAM_ALM_CPLL] = !cpll_s;
    alarm_cond[`LSAM_ALM_SPLL] = !spll_s;
    alarm_cond[`LSAM_ALM_LINK] = st_ff.link_st != lsam_pkg::LSAM_LK_DATA;
    alarm_cond[`LSAM_ALM_SYSREF] = sysref_rise && !sub0 && !mf_wrap;
    alarm_cond[`LSAM_ALM_CLK] = upset_event;
    alarm_cond[`LSAM_ALM_FIFO] = link_en && (|i_lane_fifo_err);
  end

  // Next state: registers, multiframe clock, link states, alarms, trigger.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sysref_prev = sysref_s;
    nxt_st.ball_prev = ball_s;
    nxt_st.pd_prev = global_pd;
    // Host writes to the read-write registers.
    if (i_wr) begin
      case (i_addr)
        `LSAM_ADDR_TRIM_A: nxt_st.trims[31:24] = i_wdata;
        `LSAM_ADDR_TRIM_B: nxt_st.trims[23:16] = i_wdata;
        `LSAM_ADDR_TRIM_C: nxt_st.trims[15:8] = i_wdata;
        `LSAM_ADDR_TRIM_D: nxt_st.trims[7:0] = i_wdata;
        `LSAM_ADDR_LINK_CTL: nxt_st.ctl = i_wdata;
        `LSAM_ADDR_HIDE: nxt_st.hide = i_wdata[5:0];
        `LSAM_ADDR_CHAN_PD: nxt_st.chan_pd = i_wdata[1:0];
        default: nxt_st.ctl = st_ff.ctl;
      endcase
    end
    // Sticky flags: write one clears, a new event in the same cycle wins.
    nxt_st.alarm = (st_ff.alarm & ~(wr_alarm ? i_wdata[5:0] : 6'h00)) |
                   alarm_cond;
    nxt_st.lane_err = (st_ff.lane_err & ~(wr_lane ? i_wdata : 8'h00)) |
                      (link_en ? i_lane_fifo_err : 8'h00);
    // Sysref restarts the clock unless subclass 0 leaves it free running.
    if (sysref_rise && !sub0) begin
      nxt_st.lmfc_cnt = 5'h00;
    end else if (mf_wrap) begin
      nxt_st.lmfc_cnt = 5'h00;
    end else begin
      nxt_st.lmfc_cnt = st_ff.lmfc_cnt + 5'h01;
    end
    // Link state machine; disabled link is held in reset.
    if (!link_en) begin
      nxt_st.link_st = lsam_pkg::LSAM_LK_OFF;
      nxt_st.ilas_cnt = 2'h0;
    end else begin
      case (st_ff.link_st)
        lsam_pkg::LSAM_LK_OFF: begin
          nxt_st.link_st = lsam_pkg::LSAM_LK_CGS;
        end
        lsam_pkg::LSAM_LK_CGS: begin
          if (mf_wrap && enc64) begin
            nxt_st.link_st = lsam_pkg::LSAM_LK_DATA;
          end else if (mf_wrap && sync_n_s) begin
            nxt_st.link_st = lsam_pkg::LSAM_LK_ILAS;
            nxt_st.ilas_cnt = 2'h0;
          end
        end
        lsam_pkg::LSAM_LK_ILAS: begin
          if (!sync_n_s) begin
            nxt_st.link_st = lsam_pkg::LSAM_LK_CGS;
          end else if (mf_wrap && st_ff.ilas_cnt == `LSAM_ILAS_MF) begin
            nxt_st.link_st = lsam_pkg::LSAM_LK_DATA;
          end else if (mf_wrap) begin
            nxt_st.ilas_cnt = st_ff.ilas_cnt + 2'h1;
          end
        end
        lsam_pkg::LSAM_LK_DATA: begin
          if (!enc64 && !sync_n_s) begin
            nxt_st.link_st = lsam_pkg::LSAM_LK_CGS;
          end
        end
        default: nxt_st.link_st = lsam_pkg::LSAM_LK_OFF;
      endcase
    end
    // Transition timer; foreground calibration aborts any pending one.
    nxt_st.core_transition = 1'b0;
    if (fg_cal) begin
      nxt_st.trig_busy = 1'b0;
    end else if (trig_start) begin
      nxt_st.trig_busy = 1'b1;
      nxt_st.trig_cnt = 10'h000;
    end else if (st_ff.trig_busy) begin
      nxt_st.trig_cnt = st_ff.trig_cnt + 10'h001;
      if (st_ff.trig_cnt == `LSAM_TRANS_LAST) begin
        nxt_st.trig_busy = 1'b0;
        nxt_st.core_transition = 1'b1;
      end
    end
    // Registered outputs.
    summary = nxt_st.alarm & ~nxt_st.hide;
    nxt_st.calib_status_pin = nxt_st.ctl[`LSAM_CTL_STAT_SEL] ?
                              (|summary) : nxt_st.trig_busy;
    nxt_st.lmfc_edge = (nxt_st.lmfc_cnt == 5'h00);
    nxt_st.cgs_active = nxt_st.link_st == lsam_pkg::LSAM_LK_CGS;
    nxt_st.ilas_active = nxt_st.link_st == lsam_pkg::LSAM_LK_ILAS;
    nxt_st.data_active = nxt_st.link_st == lsam_pkg::LSAM_LK_DATA;
    nxt_st.serdes_pd = !nxt_st.ctl[`LSAM_CTL_LINK_EN];
    nxt_st.fifo_rst = !nxt_st.ctl[`LSAM_CTL_LINK_EN];
    // Read data stands in the cycle after the read strobe only.
    nxt_st.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `LSAM_ADDR_TRIM_A: nxt_st.rdata = st_ff.trims[31:24];
        `LSAM_ADDR_TRIM_B: nxt_st.rdata = st_ff.trims[23:16];
        `LSAM_ADDR_TRIM_C: nxt_st.rdata = st_ff.trims[15:8];
        `LSAM_ADDR_TRIM_D: nxt_st.rdata = st_ff.trims[7:0];
        `LSAM_ADDR_LINK_CTL: nxt_st.rdata = st_ff.ctl;
        `LSAM_ADDR_ALARM: nxt_st.rdata = {2'h0, st_ff.alarm};
        `LSAM_ADDR_HIDE: nxt_st.rdata = {2'h0, st_ff.hide};
        `LSAM_ADDR_SUMMARY:
          nxt_st.rdata = {2'h0, st_ff.alarm & ~st_ff.hide};
        `LSAM_ADDR_LANE_ERR: nxt_st.rdata = st_ff.lane_err;
        `LSAM_ADDR_LINK_STAT:
          nxt_st.rdata = {5'h00, st_ff.trig_busy, st_ff.link_st};
        `LSAM_ADDR_CHAN_PD: nxt_st.rdata = {6'h00, st_ff.chan_pd};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; trims start at high performance values.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.trims <= {`LSAM_TRIM_A_RST, `LSAM_TRIM_B_RST,
                      `LSAM_TRIM_C_RST, `LSAM_TRIM_D_RST};
      st_ff.ctl <= `LSAM_CTL_RST;
      st_ff.hide <= `LSAM_HIDE_RST;
      st_ff.chan_pd <= `LSAM_CHAN_PD_RST;
      st_ff.serdes_pd <= 1'b1;
      st_ff.fifo_rst <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_lmfc_edge = st_ff.lmfc_edge;
  assign o_cgs_active = st_ff.cgs_active;
  assign o_ilas_active = st_ff.ilas_active;
  assign o_data_active = st_ff.data_active;
  assign o_serdes_pd = st_ff.serdes_pd;
  assign o_fifo_rst = st_ff.fifo_rst;
  assign o_power_trims = st_ff.trims;
  assign o_core_transition = st_ff.core_transition;
  assign o_calib_status_pin = st_ff.calib_status_pin;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_alarm_hold: assert property (
    (st_ff.alarm[`LSAM_ALM_CLK] && !wr_alarm) |=>
      st_ff.alarm[`LSAM_ALM_CLK]) else $error("alarm bit dropped");
  chk_set_beats_clear: assert property (
    (upset_event && wr_alarm) |=> st_ff.alarm[`LSAM_ALM_CLK])
    else $error("clear beat a new alarm");
  chk_upset_sets: assert property (
    (i_chan_a_clk_tick != i_chan_b_clk_tick && st_ff.chan_pd == 2'h0)
      |=> st_ff.alarm[`LSAM_ALM_CLK]) else $error("upset not flagged");
  chk_pin_alarm: assert property (
    st_ff.ctl[`LSAM_CTL_STAT_SEL] |->
      o_calib_status_pin == (|(st_ff.alarm & ~st_ff.hide)))
    else $error("status pin disagrees with alarms");
  chk_sysref_reset: assert property (
    (sysref_rise && !sub0) |=> (st_ff.lmfc_cnt == 5'h00) && o_lmfc_edge)
    else $error("sysref did not reset the clock");
  chk_free_wrap: assert property (
    (sub0 && mf_wrap) |=> st_ff.lmfc_cnt == 5'h00 ##1
      st_ff.lmfc_cnt == 5'h01) else $error("free clock not wrapping");
  chk_link_off: assert property (
    !link_en |-> (o_serdes_pd && o_fifo_rst) ##1 !o_data_active)
    else $error("disabled link still active");
  chk_cgs_start: assert property (
    (link_en && !enc64 && st_ff.link_st == lsam_pkg::LSAM_LK_DATA &&
     !sync_n_s) |=> o_cgs_active) else $error("sync request ignored");
  chk_trans_delay: assert property (
    (trig_start && !fg_cal) |-> ##1 (!o_core_transition)[*8] ##[491:991]
      (o_core_transition || fg_cal)) else $error("transition mistimed");
  chk_fg_quiet: assert property (
    fg_cal |=> !o_core_transition) else $error("transition in foreground");
endmodule
`default_nettype wire

// ---- test/lsam_rx_model.sv ----
// Receiver-side model: asks for code group sync and marks release points.
// Assumes it shares the clock and reset of the transmitter under test.
`default_nettype none
module lsam_rx_model #(
  parameter int RBD = 0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lmfc_edge,
  input wire logic i_cgs_active,
  input wire logic i_ilas_active,
  input wire logic i_data_active,
  output logic o_sync_n,
  output logic o_release
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cgs_cnt;
  logic [4:0] phase;
  // Holds sync low until eight code group cycles are seen, and lowers it
  // again once the link has left every active state.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cgs_cnt <= 4'h0;
      o_sync_n <= 1'b0;
    end else begin
      if (!i_cgs_active) begin
        cgs_cnt <= 4'h0;
      end else if (cgs_cnt != 4'h8) begin
        cgs_cnt <= cgs_cnt + 4'h1;
      end
      if (cgs_cnt == 4'h8) begin
        o_sync_n <= 1'b1;
      end else if (!i_cgs_active && !i_ilas_active && !i_data_active) begin
        o_sync_n <= 1'b0;
      end
    end
  end
  // Release point sits RBD frame clocks after each multiframe edge and
  // fires only once every lane is delivering data.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 5'h0;
      o_release <= 1'b0;
    end else begin
      phase <= i_lmfc_edge ? 5'h0 : phase + 5'h1;
      o_release <= i_data_active && (phase == 5'(RBD));
    end
  end
endmodule
`default_nettype wire

// ---- test/lsam_top_tb.sv ----
// Self-checking bench for the link timing, alarm and power mode block.
// Assumes the design files under hw/ and the receiver model compiled.
`default_nettype none
`include "lsam_map.svh"
module lsam_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, sysref = 1'b0, ball = 1'b0;
  logic cpll = 1'b0, spll = 1'b0, tick_a = 1'b0, tick_b = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, lane_err = 8'h00, rdata;
  logic lmfc, cgs, ilas, dat, spd, frst, ctr, stp, sync_n, ilas_seen, rel;
  logic pd = 1'b0, ilas_clr = 1'b0;
  logic [31:0] trims;
  int failures = 0;
  int compares = 0;
  // Free-running 20 MHz sample clock.
  always #25 clk = ~clk;
  // Remembers whether the alignment sequence showed up in a link run.
  always @(posedge clk) begin
    ilas_seen <= ilas_clr ? 1'b0 : (ilas_seen || ilas === 1'b1);
  end
  lsam_top lsam_top_i (.i_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_sysref(sysref),
    .i_sync_n(sync_n), .i_cal_trigger_ball(ball), .i_pd_pin(pd),
    .i_cpll_lock(cpll), .i_spll_lock(spll), .i_chan_a_clk_tick(tick_a),
    .i_chan_b_clk_tick(tick_b), .i_lane_fifo_err(lane_err),
    .o_rdata(rdata), .o_lmfc_edge(lmfc), .o_cgs_active(cgs),
    .o_ilas_active(ilas), .o_data_active(dat), .o_serdes_pd(spd),
    .o_fifo_rst(frst), .o_power_trims(trims), .o_core_transition(ctr),
    .o_calib_status_pin(stp));
  lsam_rx_model lsam_rx_model_i (.i_clk(clk), .i_rst(rst),
    .i_lmfc_edge(lmfc), .i_cgs_active(cgs), .i_ilas_active(ilas),
    .i_data_active(dat), .o_sync_n(sync_n), .o_release(rel));
  // Prints the verdict and stops the run.
  task automatic finish_test();
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Lets n edges pass, then settles just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle register write on the plain port.
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read; the data stand only in the following cycle.
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({24'h0, rdata & m}, {24'h0, e});
  endtask
  // Waits a bounded number of cycles for a flag; a timeout ends the run.
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        failures++;
        finish_test();
      end
    end
  endtask
  // Trim defaults, write-only kick, unmapped place and alarms after reset.
  task automatic t_reset();
    rd_reg(10'h037, 8'h4b);
    rd_reg(10'h29a, 8'h0f);
    rd_reg(10'h29b, 8'h04);
    rd_reg(10'h29c, 8'h1b);
    chk(trims, 32'h4b0f_041b);
    wr_reg(10'h3ff, 8'hff);
    rd_reg(10'h3ff, 8'h00);
    rd_reg(`LSAM_ADDR_SOFT_KICK, 8'h00);
    rd_reg(`LSAM_ADDR_ALARM, 8'h07);
  endtask
  // Switches to low power and back while calibration and link are off.
  task automatic t_trim();
    logic [31:0] v;
    for (int m = 0; m < 2; m++) begin
      v = m ? 32'h4b0f_041b : 32'h4606_0014;
      wr_reg(10'h037, v[31:24]);
      wr_reg(10'h29a, v[23:16]);
      wr_reg(10'h29b, v[15:8]);
      wr_reg(10'h29c, v[7:0]);
      tick(1);
      chk(trims, v);
      rd_reg(10'h29b, v[15:8]);
    end
  endtask
  // Sticky flags, write-one clear, hiding and the status pin.
  task automatic t_alarm();
    @(posedge clk);
    cpll <= 1'b1;
    spll <= 1'b1;
    tick(5);
    wr_reg(`LSAM_ADDR_ALARM, 8'h02);
    rd_reg(`LSAM_ADDR_ALARM, 8'h05);
    wr_reg(`LSAM_ADDR_ALARM, 8'h00);
    rd_reg(`LSAM_ADDR_ALARM, 8'h05);
    wr_reg(`LSAM_ADDR_HIDE, 8'h01);
    rd_reg(`LSAM_ADDR_SUMMARY, 8'h04);
    wr_reg(`LSAM_ADDR_LINK_CTL, 8'h40);
    tick(1);
    chk(stp, 1'b1);
    wr_reg(`LSAM_ADDR_HIDE, 8'h05);
    wr_reg(`LSAM_ADDR_ALARM, 8'h01);
    tick(1);
    chk(stp, 1'b0);
    @(posedge clk);
    cpll <= 1'b0;
    repeat (3) @(posedge clk);
    cpll <= 1'b1;
    tick(4);
    rd_reg(`LSAM_ADDR_ALARM, 8'h05);
    wr_reg(`LSAM_ADDR_ALARM, 8'h01);
    wr_reg(`LSAM_ADDR_HIDE, 8'h00);
  endtask
  // Channel clock mismatch, with one channel down and then both powered.
  task automatic t_upset();
    for (int p = 0; p < 2; p++) begin
      wr_reg(`LSAM_ADDR_CHAN_PD, p ? 8'h00 : 8'h01);
      rd_reg(`LSAM_ADDR_CHAN_PD, p ? 8'h00 : 8'h01);
      @(posedge clk);
      tick_a <= 1'b1;
      @(posedge clk);
      tick_a <= 1'b0;
      tick(3);
      rd_reg(`LSAM_ADDR_ALARM, p ? 8'h14 : 8'h04);
    end
    wr_reg(`LSAM_ADDR_ALARM, 8'h10);
    rd_reg(`LSAM_ADDR_ALARM, 8'h04);
    // A mismatch in the same cycle as the clearing write keeps the flag.
    @(posedge clk);
    tick_a <= 1'b1;
    wr <= 1'b1;
    addr <= `LSAM_ADDR_ALARM;
    wdata <= 8'h10;
    @(posedge clk);
    tick_a <= 1'b0;
    wr <= 1'b0;
    rd_reg(`LSAM_ADDR_ALARM, 8'h10, 8'h10);
    wr_reg(`LSAM_ADDR_ALARM, 8'h10);
    wr_reg(`LSAM_ADDR_LINK_CTL, 8'h80);
    wr_reg(`LSAM_ADDR_LINK_CTL, 8'h00);
    tick(3);
    rd_reg(`LSAM_ADDR_ALARM, 8'h10, 8'h10);
    wr_reg(`LSAM_ADDR_ALARM, 8'h10);
    // Leaving power-down through the pin flags an upset as well.
    @(posedge clk);
    pd <= 1'b1;
    repeat (4) @(posedge clk);
    pd <= 1'b0;
    tick(5);
    rd_reg(`LSAM_ADDR_ALARM, 8'h10, 8'h10);
    wr_reg(`LSAM_ADDR_ALARM, 8'h10);
  endtask
  // Brings the link up in subclass 0, checks lane errors, takes it down.
  task automatic t_link(input logic [7:0] c);
    int n;
    @(posedge clk);
    ilas_clr <= 1'b1;
    @(posedge clk);
    ilas_clr <= 1'b0;
    wr_reg(`LSAM_ADDR_LINK_CTL, c);
    wait_hi(cgs, 8, n);
    chk({spd, frst}, 2'b00);
    wait_hi(dat, 400, n);
    chk(ilas_seen, !c[2]);
    rd_reg(`LSAM_ADDR_LINK_STAT, 8'h03);
    wait_hi(rel, 40, n);
    chk(dat, 1'b1);
    wait_hi(lmfc, 40, n);
    tick(1);
    wait_hi(lmfc, 40, n);
    chk(n, 31);
    wr_reg(`LSAM_ADDR_ALARM, 8'h04);
    rd_reg(`LSAM_ADDR_ALARM, 8'h00);
    @(posedge clk);
    lane_err <= 8'h08;
    @(posedge clk);
    lane_err <= 8'h00;
    tick(3);
    rd_reg(`LSAM_ADDR_LANE_ERR, 8'h08);
    rd_reg(`LSAM_ADDR_ALARM, 8'h20);
    wr_reg(`LSAM_ADDR_LANE_ERR, 8'h08);
    wr_reg(`LSAM_ADDR_ALARM, 8'h20);
    rd_reg(`LSAM_ADDR_LANE_ERR, 8'h00);
    wr_reg(`LSAM_ADDR_LINK_CTL, 8'h00);
    tick(1);
    chk({spd, frst, cgs, ilas, dat}, 5'b11000);
  endtask
  // A sysref rise mid-multiframe restarts the multiframe clock.
  task automatic t_sysref();
    int n;
    wait_hi(lmfc, 40, n);
    tick(10);
    @(posedge clk);
    sysref <= 1'b1;
    wait_hi(lmfc, 8, n);
    chk(n >= 2 && n <= 6, 1'b1);
    tick(1);
    wait_hi(lmfc, 40, n);
    chk(n, 31);
    @(posedge clk);
    sysref <= 1'b0;
    rd_reg(`LSAM_ADDR_ALARM, 8'h08, 8'h08);
    wr_reg(`LSAM_ADDR_ALARM, 8'h08);
  endtask
  // Fires a trigger by ball or by kick and counts core transitions.
  task automatic t_trig(input logic [7:0] c, input logic b,
                        input int exp);
    int n;
    int hits;
    int first;
    hits = 0;
    first = 0;
    wr_reg(`LSAM_ADDR_LINK_CTL, c);
    if (b) begin
      @(posedge clk);
      ball <= 1'b1;
    end else begin
      wr_reg(`LSAM_ADDR_SOFT_KICK, 8'h01);
    end
    for (n = 1; n <= 1100; n++) begin
      tick(1);
      if (n == 10) chk(stp, exp != 0);
      if (ctr === 1'b1) begin
        hits++;
        if (first == 0) first = n;
      end
    end
    chk(hits, exp);
    if (exp != 0) chk(first >= 500 && first <= 1000, 1'b1);
    @(posedge clk);
    ball <= 1'b0;
  endtask
  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(4);
    t_reset();
    t_trim();
    t_alarm();
    t_upset();
    t_link(8'h03);
    t_link(8'h07);
    t_sysref();
    t_trig(8'h18, 1'b0, 1);
    t_trig(8'h18, 1'b1, 1);
    t_trig(8'h38, 1'b1, 0);
    finish_test();
  end
endmodule
`default_nettype wire
